// ===== hw/srtg_params.svh
// constants for the speed ramp time generator: defaults, limits, timing
// assumes a 200 MHz core clock; included by the ramp module
`ifndef SRTG_PARAMS_SVH
`define SRTG_PARAMS_SVH

`define SRTG_CLK_PERIOD_PS 5000
`define SRTG_TICK_US 1000
`define SRTG_TICK_CYCLES ((`SRTG_TICK_US * 1000000) / `SRTG_CLK_PERIOD_PS)
`define SRTG_TICKS_PER_S (1000000 / `SRTG_TICK_US)

`define SRTG_DEF_ACCEL_S 16'h0005
`define SRTG_DEF_DECEL_S 16'h0005
`define SRTG_DEF_REF_RPM 16'h0BB8
`define SRTG_DEF_ACCEL2_S 16'h0005
`define SRTG_DEF_DECEL2_S 16'h270F
`define SRTG_DEF_LS_ACCEL_S 16'h270F
`define SRTG_DEF_LS_DECEL_S 16'h270F
`define SRTG_DEF_VISIBILITY 16'h0000
`define SRTG_DEF_GAIN_A 16'h0000
`define SRTG_DEF_GAIN_B 16'h0000
`define SRTG_DEF_PROFILE 2'h0
`define SRTG_DEF_TERM_FUNC 3'h0

`define SRTG_TIME_UNSET 16'h270F
`define SRTG_TIME_MAX_S 16'h0E10
`define SRTG_REF_MIN_RPM 16'h001E
`define SRTG_REF_MAX_RPM 16'h2EE0
`define SRTG_LOW_SPEED_RPM 16'h012C
`define SRTG_RATED_RPM 16'h0BB8
`define SRTG_FUNC_SECOND_SET 3'h3
`define SRTG_PROFILE_S_A 2'h1
`define SRTG_NUM_TERMS 5
`define SRTG_FRAC_BITS 16
`define SRTG_DIV_STEPS 6'h20

`endif

// ===== hw/srtg_pkg.sv
// types shared by the speed ramp time generator
// assumes srtg_params.svh sits on the include path
package srtg_pkg;

  // which setting a write targets
  typedef enum logic [3:0] {
    SRTG_SEL_ACCEL = 4'h0,
    SRTG_SEL_DECEL = 4'h1,
    SRTG_SEL_REF = 4'h2,
    SRTG_SEL_ACCEL2 = 4'h3,
    SRTG_SEL_DECEL2 = 4'h4,
    SRTG_SEL_LS_ACCEL = 4'h5,
    SRTG_SEL_LS_DECEL = 4'h6,
    SRTG_SEL_VISIBILITY = 4'h7,
    SRTG_SEL_GAIN_A = 4'h8,
    SRTG_SEL_GAIN_B = 4'h9,
    SRTG_SEL_TERM_FUNC = 4'hA,
    SRTG_SEL_PROFILE = 4'hB
  } srtg_sel_t;

  typedef struct packed {
    srtg_sel_t sel;
    logic [15:0] data;
  } srtg_wr_t;

  typedef struct packed {
    logic [15:0] gain_a;
    logic [15:0] gain_b;
  } srtg_gain_t;

  typedef enum logic [2:0] {
    SRTG_ST_IDLE = 3'b001,
    SRTG_ST_DIV = 3'b010,
    SRTG_ST_APPLY = 3'b100
  } srtg_state_t;

endpackage : srtg_pkg

// ===== hw/srtg_ramp.sv
// speed ramp generator: moves operating speed toward the set speed
// assumes command inputs come from core-clock logic; terminals are async pins
`include "srtg_params.svh"
//
// Behaviour
// - primary accel time is stop-to-reference-speed time, constant rising slope
// - primary decel time is reference-speed-to-stop time, constant falling slope
// - every ramp time scales against the programmable reference speed, except under S-pattern A
// - second time set replaces primary only while second-set select is high
// - with select high, second accel time governs accel and default decel
// - second decel time 9999 means decelerate using second accel time
// - second-set select comes from a terminal whose function code is 3
// - below 300 r/min accel uses low-speed accel time; 9999 means primary
// - below 300 r/min decel uses low-speed decel time; 9999 means primary
// - low-speed time shorter than primary acts as the primary time
// - with S-pattern A profile, times scale to rated speed instead
// - changing reference speed leaves the analog gain settings untouched
// - reference and second-set settings writable only when visibility is 0
// - operating speed follows set speed while start is high, else ramps to 0, using the times selected above
module srtg_ramp #(
  parameter int unsigned TICK_CYCLES = `SRTG_TICK_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [15:0] i_set_speed,
  input wire logic i_start,
  input wire logic [`SRTG_NUM_TERMS-1:0] i_term,
  input wire logic i_wr_valid,
  input wire srtg_pkg::srtg_wr_t i_wr,
  output logic [15:0] o_speed,
  output logic o_at_target,
  output logic o_second_set_select,
  output logic o_wr_refused,
  output srtg_pkg::srtg_gain_t o_gain
);

  logic [15:0] accel_time_r;
  logic [15:0] decel_time_r;
  logic [15:0] ramp_reference_speed_r;
  logic [15:0] second_accel_time_r;
  logic [15:0] second_decel_time_r;
  logic [15:0] low_speed_accel_time_r;
  logic [15:0] low_speed_decel_time_r;
  logic [15:0] extended_param_visibility_r;
  logic [1:0] ramp_profile_select_r;
  logic [2:0] input_terminal_function_sel_r [`SRTG_NUM_TERMS];
  logic [`SRTG_NUM_TERMS-1:0] term_meta_r;
  logic [`SRTG_NUM_TERMS-1:0] term_sync_r;
  logic [`SRTG_NUM_TERMS-1:0] term_hit;
  logic second_set_select;
  logic wr_ok;
  logic time_ok;
  logic visible;

  // two-flop sync on terminal pins before any decode
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      term_meta_r <= '0;
      term_sync_r <= '0;
    end else begin
      term_meta_r <= i_term;
      term_sync_r <= term_meta_r;
    end
  end

  for (genvar g = 0; g < `SRTG_NUM_TERMS; g++) begin : g_term
    // one function code per terminal, each written only through its own index
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        input_terminal_function_sel_r[g] <= `SRTG_DEF_TERM_FUNC;
      end else if (i_wr_valid && wr_ok && (i_wr.sel == srtg_pkg::SRTG_SEL_TERM_FUNC)
                   && (i_wr.data[6:4] == 3'(g))) begin
        input_terminal_function_sel_r[g] <= i_wr.data[2:0];
      end
    end
    assign term_hit[g] = term_sync_r[g] && (input_terminal_function_sel_r[g] == `SRTG_FUNC_SECOND_SET);
  end
  assign second_set_select = |term_hit;

  // settings writes
  assign visible = (extended_param_visibility_r == 16'h0000);
  assign time_ok = (i_wr.data <= `SRTG_TIME_MAX_S);
  always_comb begin
    wr_ok = 1'b0;
    case (i_wr.sel)
      srtg_pkg::SRTG_SEL_ACCEL, srtg_pkg::SRTG_SEL_DECEL: wr_ok = time_ok;
      srtg_pkg::SRTG_SEL_REF: wr_ok = visible && (i_wr.data >= `SRTG_REF_MIN_RPM)
                                      && (i_wr.data <= `SRTG_REF_MAX_RPM);
      srtg_pkg::SRTG_SEL_ACCEL2: wr_ok = visible && time_ok;
      srtg_pkg::SRTG_SEL_DECEL2: wr_ok = visible && (time_ok || i_wr.data == `SRTG_TIME_UNSET);
      srtg_pkg::SRTG_SEL_LS_ACCEL, srtg_pkg::SRTG_SEL_LS_DECEL:
        wr_ok = time_ok || (i_wr.data == `SRTG_TIME_UNSET);
      srtg_pkg::SRTG_SEL_VISIBILITY, srtg_pkg::SRTG_SEL_GAIN_A, srtg_pkg::SRTG_SEL_GAIN_B: wr_ok = 1'b1;
      srtg_pkg::SRTG_SEL_TERM_FUNC: wr_ok = (i_wr.data[6:4] < 3'(`SRTG_NUM_TERMS));
      srtg_pkg::SRTG_SEL_PROFILE: wr_ok = (i_wr.data[15:2] == 14'h0000) && (i_wr.data[1:0] != 2'h3);
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      accel_time_r <= `SRTG_DEF_ACCEL_S;
      decel_time_r <= `SRTG_DEF_DECEL_S;
      ramp_reference_speed_r <= `SRTG_DEF_REF_RPM;
      second_accel_time_r <= `SRTG_DEF_ACCEL2_S;
      second_decel_time_r <= `SRTG_DEF_DECEL2_S;
      low_speed_accel_time_r <= `SRTG_DEF_LS_ACCEL_S;
      low_speed_decel_time_r <= `SRTG_DEF_LS_DECEL_S;
      extended_param_visibility_r <= `SRTG_DEF_VISIBILITY;
      ramp_profile_select_r <= `SRTG_DEF_PROFILE;
      o_gain <= '{gain_a: `SRTG_DEF_GAIN_A, gain_b: `SRTG_DEF_GAIN_B};
    end else if (i_wr_valid && wr_ok) begin
      // gains only change by their own writes, never with the reference
      case (i_wr.sel)
        srtg_pkg::SRTG_SEL_ACCEL: accel_time_r <= i_wr.data;
        srtg_pkg::SRTG_SEL_DECEL: decel_time_r <= i_wr.data;
        srtg_pkg::SRTG_SEL_REF: ramp_reference_speed_r <= i_wr.data;
        srtg_pkg::SRTG_SEL_ACCEL2: second_accel_time_r <= i_wr.data;
        srtg_pkg::SRTG_SEL_DECEL2: second_decel_time_r <= i_wr.data;
        srtg_pkg::SRTG_SEL_LS_ACCEL: low_speed_accel_time_r <= i_wr.data;
        srtg_pkg::SRTG_SEL_LS_DECEL: low_speed_decel_time_r <= i_wr.data;
        srtg_pkg::SRTG_SEL_VISIBILITY: extended_param_visibility_r <= i_wr.data;
        srtg_pkg::SRTG_SEL_GAIN_A: o_gain.gain_a <= i_wr.data;
        srtg_pkg::SRTG_SEL_GAIN_B: o_gain.gain_b <= i_wr.data;
        srtg_pkg::SRTG_SEL_PROFILE: ramp_profile_select_r <= i_wr.data[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wr_refused <= 1'b0;
      o_second_set_select <= 1'b0;
    end else begin
      o_wr_refused <= i_wr_valid && !wr_ok;
      o_second_set_select <= second_set_select;
    end
  end

  // ramp timing
  logic [31:0] speed_acc_r;
  logic [31:0] target;
  logic [15:0] target_rpm;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic rising;
  logic low_speed;
  logic [15:0] base_time;
  logic [15:0] low_time;
  logic [15:0] active_time;
  logic [15:0] scale_rpm;
  srtg_pkg::srtg_state_t state_r;
  logic [5:0] div_cnt_r;
  logic [31:0] num_r;
  logic [31:0] quo_r;
  logic [22:0] rem_r;
  logic [22:0] den_r;
  logic [23:0] rem_shift;
  logic step_up_r;

  assign target_rpm = i_start ? i_set_speed : 16'h0000;
  assign target = {target_rpm, 16'h0000};
  assign rising = (target > speed_acc_r);
  assign low_speed = (speed_acc_r[31:16] < `SRTG_LOW_SPEED_RPM);
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  always_comb begin
    if (rising) begin
      base_time = second_set_select ? second_accel_time_r : accel_time_r;
      low_time = low_speed_accel_time_r;
    end else begin
      if (second_set_select) begin
        base_time = (second_decel_time_r == `SRTG_TIME_UNSET) ? second_accel_time_r
                                                                 : second_decel_time_r;
      end else begin
        base_time = decel_time_r;
      end
      low_time = low_speed_decel_time_r;
    end
    active_time = base_time;
    // a low-speed time below the primary cannot make the ramp steeper
    if (low_speed && (low_time != `SRTG_TIME_UNSET) && (low_time > base_time)) begin
      active_time = low_time;
    end
    scale_rpm = (ramp_profile_select_r == `SRTG_PROFILE_S_A) ? `SRTG_RATED_RPM
                                                             : ramp_reference_speed_r;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
    end
  end

  // serial divide spreads the slope math over the tick; needs ticks of at least 34 cycles
  assign rem_shift = {rem_r, num_r[31]};
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= srtg_pkg::SRTG_ST_IDLE;
      div_cnt_r <= '0;
      num_r <= '0;
      quo_r <= '0;
      rem_r <= '0;
      den_r <= '0;
      step_up_r <= 1'b0;
    end else begin
      case (state_r)
        srtg_pkg::SRTG_ST_IDLE: begin
          if (tick) begin
            step_up_r <= rising;
            if (active_time == 16'h0000) begin
              quo_r <= 32'hFFFF_FFFF;
              state_r <= srtg_pkg::SRTG_ST_APPLY;
            end else begin
              num_r <= {scale_rpm, 16'h0000};
              den_r <= 23'(active_time * `SRTG_TICKS_PER_S);
              rem_r <= '0;
              quo_r <= '0;
              div_cnt_r <= `SRTG_DIV_STEPS;
              state_r <= srtg_pkg::SRTG_ST_DIV;
            end
          end
        end
        srtg_pkg::SRTG_ST_DIV: begin
          num_r <= {num_r[30:0], 1'b0};
          if (rem_shift >= {1'b0, den_r}) begin
            rem_r <= 23'(rem_shift - {1'b0, den_r});
            quo_r <= {quo_r[30:0], 1'b1};
          end else begin
            rem_r <= rem_shift[22:0];
            quo_r <= {quo_r[30:0], 1'b0};
          end
          div_cnt_r <= div_cnt_r - 6'h01;
          if (div_cnt_r == 6'h01) begin
            state_r <= srtg_pkg::SRTG_ST_APPLY;
          end
        end
        srtg_pkg::SRTG_ST_APPLY: state_r <= srtg_pkg::SRTG_ST_IDLE;
        default: state_r <= srtg_pkg::SRTG_ST_IDLE;
      endcase
    end
  end

  logic [32:0] sum_up;
  logic [32:0] diff_dn;
  assign sum_up = {1'b0, speed_acc_r} + {1'b0, quo_r};
  assign diff_dn = {1'b0, speed_acc_r} - {1'b0, quo_r};

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      speed_acc_r <= '0;
    end else if (state_r == srtg_pkg::SRTG_ST_APPLY) begin
      // direction re-checked so a target change mid-divide never overshoots
      if (step_up_r && rising) begin
        speed_acc_r <= (sum_up >= {1'b0, target}) ? target : sum_up[31:0];
      end else if (!step_up_r && (target < speed_acc_r)) begin
        speed_acc_r <= (diff_dn[32] || diff_dn[31:0] <= target) ? target : diff_dn[31:0];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_speed <= '0;
      o_at_target <= 1'b0;
    end else begin
      o_speed <= speed_acc_r[31:16];
      o_at_target <= (speed_acc_r == target);
    end
  end

endmodule : srtg_ramp

// ===== tb/srtg_motor_stub.sv
// motor stage stand-in: follows the ramped speed one cycle late
// assumes the ramp's clock and reset
module srtg_motor_stub (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [15:0] i_speed,
  output logic [15:0] o_shaft_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  // ideal shaft: no inertia, so ramp slopes show unchanged
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_shaft_speed <= 16'h0000;
    end else begin
      o_shaft_speed <= i_speed;
    end
  end
endmodule : srtg_motor_stub

// ===== tb/srtg_ramp_sva.sv
// checker for the speed ramp generator ports
// assumes binding onto srtg_ramp; sees its ports only
module srtg_ramp_sva #(
  parameter int unsigned TICK_CYCLES = 64
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [15:0] i_set_speed,
  input wire logic i_start,
  input wire logic [4:0] i_term,
  input wire logic i_wr_valid,
  input wire srtg_pkg::srtg_wr_t i_wr,
  input wire logic [15:0] o_speed,
  input wire logic o_at_target,
  input wire logic o_second_set_select,
  input wire logic o_wr_refused,
  input wire srtg_pkg::srtg_gain_t o_gain
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  logic vis_nz_r;
  logic [4:0] map_r;
  logic sel_exp;
  // mirrors of two settings, since only writes are visible here
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      vis_nz_r <= 1'b0;
    end else if (i_wr_valid && i_wr.sel == srtg_pkg::SRTG_SEL_VISIBILITY) begin
      vis_nz_r <= (i_wr.data != 16'h0000);
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      map_r <= 5'h00;
    end else if (i_wr_valid && i_wr.sel == srtg_pkg::SRTG_SEL_TERM_FUNC && i_wr.data[6:4] < 3'h5) begin
      map_r[i_wr.data[6:4]] <= (i_wr.data[2:0] == 3'h3);
    end
  end
  assign sel_exp = |(i_term & map_r);
  refuse_pulse_a: assert property (!i_wr_valid |=> !o_wr_refused) else $error("refusal held too long");
  refuse_cause_a: assert property (o_wr_refused |-> $past(i_wr_valid)) else $error("refusal with no write");
  hidden_write_a: assert property (i_wr_valid && vis_nz_r && i_wr.sel inside {srtg_pkg::SRTG_SEL_REF,
    srtg_pkg::SRTG_SEL_ACCEL2, srtg_pkg::SRTG_SEL_DECEL2} |=> o_wr_refused) else $error("hidden write taken");
  time_range_a: assert property (i_wr_valid && i_wr.sel == srtg_pkg::SRTG_SEL_ACCEL && i_wr.data > 16'h0E10
    |=> o_wr_refused) else $error("long accel time taken");
  ref_range_a: assert property (i_wr_valid && i_wr.sel == srtg_pkg::SRTG_SEL_REF
    && (i_wr.data < 16'h001E || i_wr.data > 16'h2EE0) |=> o_wr_refused) else $error("bad reference taken");
  gain_hold_a: assert property (!(i_wr_valid && i_wr.sel inside {srtg_pkg::SRTG_SEL_GAIN_A,
    srtg_pkg::SRTG_SEL_GAIN_B}) |=> $stable(o_gain)) else $error("gain moved without write");
  speed_pace_a: assert property ($changed(o_speed) |=> $stable(o_speed) [*8]) else $error("speed moved twice");
  sel_on_a: assert property (sel_exp [*4] |-> o_second_set_select) else $error("second set not chosen");
  sel_off_a: assert property ((!sel_exp) [*4] |-> !o_second_set_select) else $error("second set stuck");
  jump_c: cover property (o_at_target && i_start);
  refuse_c: cover property (o_wr_refused);
  second_c: cover property (o_second_set_select && $changed(o_speed));
endmodule : srtg_ramp_sva

// ===== tb/test_srtg_ramp.sv
// testbench for the speed ramp generator
// assumes TICK_CYCLES 64, so 1 s of ramp time is 64000 cycles
module test_srtg_ramp;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, start = 0, wv = 0;
  logic [15:0] set = 16'h0000, speed, shaft, old;
  logic [4:0] term = 5'h00;
  srtg_pkg::srtg_wr_t wr = '0;
  srtg_pkg::srtg_gain_t gain;
  logic at_t, sel2, refused;
  int errors = 0, cmp_count = 0;
  initial forever #2.5 clk = ~clk;
  srtg_ramp #(.TICK_CYCLES(64)) DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_set_speed(set), .i_start(start),
    .i_term(term), .i_wr_valid(wv), .i_wr(wr), .o_speed(speed), .o_at_target(at_t),
    .o_second_set_select(sel2), .o_wr_refused(refused), .o_gain(gain));
  srtg_motor_stub MOT (.i_core_clk(clk), .i_rst_b(rst_b), .i_speed(speed), .o_shaft_speed(shaft));
  task final_report;
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task wrs(input logic [3:0] s, input logic [15:0] d, input logic exp_ref);
    @(negedge clk);
    wv = 1'b1;
    wr.sel = srtg_pkg::srtg_sel_t'(s);
    wr.data = d;
    @(negedge clk);
    wv = 1'b0;
    check("refused", {15'h0000, refused}, {15'h0000, exp_ref});
  endtask : wrs
  // first speed change after a new target, one tick's step
  task step(input logic [15:0] tgt, input logic [15:0] exp);
    @(negedge clk);
    set = tgt;
    old = speed;
    for (int i = 0; i < 200 && speed === old; i++) @(negedge clk);
    check("speed", speed, exp);
  endtask : step
  // zero times: the target is reached on the next tick
  task land(input logic [15:0] tgt);
    @(negedge clk);
    set = tgt;
    for (int i = 0; i < 300 && speed !== tgt; i++) @(negedge clk);
    check("landed", speed, tgt);
  endtask : land
  initial begin
    repeat (6) @(negedge clk);
    check("reset speed", speed, 16'h0000);
    check("reset gain", gain.gain_a, 16'h0000);
    check("reset gain b", gain.gain_b, 16'h0000);
    rst_b = 1'b1;
    start = 1'b1;
    wrs(4'h8, 16'h1234, 1'b0);
    wrs(4'h9, 16'h5678, 1'b0);
    wrs(4'h0, 16'h0E11, 1'b1);
    wrs(4'h2, 16'h001D, 1'b1);
    wrs(4'h2, 16'h2EE1, 1'b1);
    wrs(4'hC, 16'h0000, 1'b1);
    wrs(4'h7, 16'h0001, 1'b0);
    wrs(4'h2, 16'h0BB8, 1'b1);
    wrs(4'h3, 16'h0001, 1'b1);
    wrs(4'h7, 16'h0000, 1'b0);
    wrs(4'h0, 16'h0000, 1'b0);
    wrs(4'h1, 16'h0000, 1'b0);
    land(16'h01F4);
    @(negedge clk);
    check("at target", {15'h0000, at_t}, 16'h0001);
    wrs(4'h1, 16'h0001, 1'b0);
    step(16'h0190, 16'h01F1);
    wrs(4'h1, 16'h0000, 1'b0);
    land(16'h0190);
    wrs(4'h0, 16'h0001, 1'b0);
    step(16'h0258, 16'h0193);
    wrs(4'h0, 16'h0000, 1'b0);
    land(16'h0258);
    wrs(4'h2, 16'h1770, 1'b0);
    wrs(4'hB, 16'h0001, 1'b0);
    wrs(4'h0, 16'h0001, 1'b0);
    step(16'h0320, 16'h025B);
    wrs(4'hB, 16'h0000, 1'b0);
    step(16'h0320, 16'h0261);
    wrs(4'h0, 16'h0000, 1'b0);
    land(16'h0320);
    wrs(4'h2, 16'h0BB8, 1'b0);
    check("gain a", gain.gain_a, 16'h1234);
    check("gain b", gain.gain_b, 16'h5678);
    wrs(4'hA, 16'h0003, 1'b0);
    term = 5'h01;
    repeat (4) @(negedge clk);
    check("second set", {15'h0000, sel2}, 16'h0001);
    wrs(4'h3, 16'h0001, 1'b0);
    step(16'h0384, 16'h0323);
    wrs(4'h3, 16'h0000, 1'b0);
    land(16'h0384);
    wrs(4'h1, 16'h0001, 1'b0);
    land(16'h0064);
    wrs(4'h4, 16'h0002, 1'b0);
    step(16'h0000, 16'h0062);
    term = 5'h00;
    step(16'h0000, 16'h005F);
    check("second set off", {15'h0000, sel2}, 16'h0000);
    wrs(4'h1, 16'h0000, 1'b0);
    land(16'h0000);
    wrs(4'h0, 16'h0001, 1'b0);
    wrs(4'h5, 16'h0002, 1'b0);
    step(16'h0190, 16'h0001);
    step(16'h0190, 16'h0003);
    wrs(4'h5, 16'h0000, 1'b0);
    step(16'h0190, 16'h0006);
    wrs(4'h1, 16'h0001, 1'b0);
    wrs(4'h6, 16'h0002, 1'b0);
    step(16'h0000, 16'h0004);
    @(negedge clk);
    check("shaft", shaft, 16'h0004);
    // reset in mid-run must bring back zero speed, zero gains, second set off and the default accel time
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    check("rerun speed", speed, 16'h0000);
    check("rerun shaft", shaft, 16'h0000);
    check("rerun gain a", gain.gain_a, 16'h0000);
    check("rerun gain b", gain.gain_b, 16'h0000);
    check("rerun second set", {15'h0000, sel2}, 16'h0000);
    rst_b = 1'b1;
    step(16'h0190, 16'h0001);
    final_report();
  end
  // whole sequence needs under 5000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule : test_srtg_ramp
bind srtg_ramp srtg_ramp_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_set_speed(i_set_speed), .i_start(i_start), .i_term(i_term), .i_wr_valid(i_wr_valid), .i_wr(i_wr),
  .o_speed(o_speed), .o_at_target(o_at_target), .o_second_set_select(o_second_set_select),
  .o_wr_refused(o_wr_refused), .o_gain(o_gain));
